// *** fsrc_device.sv ***
/*
  fsrc_device: flash device end; decodes serial instructions and runs a
  modelled erase/program sequencer with suspend and resume.
  Assumes: link pins are asynchronous to mclk and are synchronised here.
*/
`timescale 1ns/1ns
module fsrc_device
  import fsrc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  fsrc_link_if.device link,
  output logic busy,
  output logic suspended,
  output logic suspend_supported,
  output logic [FSRC_ADDR_W-1:0] op_addr
);
  typedef enum logic [2:0] {FSRC_D_IDLE, FSRC_D_RUN, FSRC_D_SUSPENDING, FSRC_D_SUSP}
    fsrc_dstate_t;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] sclk_s_ff, cs_s_ff, mosi_s_ff;
  logic sclk_d_ff;
  // two stages per pin, then one more on sclk for edge finding
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_s_ff <= 2'h0;
      cs_s_ff <= 2'h3;
      mosi_s_ff <= 2'h0;
      sclk_d_ff <= 1'b0;
    end else if (clk_en) begin
      sclk_s_ff <= {sclk_s_ff[0], link.sclk};
      cs_s_ff <= {cs_s_ff[0], link.cs_n};
      mosi_s_ff <= {mosi_s_ff[0], link.mosi};
      sclk_d_ff <= sclk_s_ff[1];
    end
  end
  wire sclk_rise = sclk_s_ff[1] & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s_ff[1] & sclk_d_ff;
  wire cs_act = ~cs_s_ff[1];

  // ----------------------------------------------------------------------
  // frame shifter: opcode then 24-bit address
  // ----------------------------------------------------------------------
  logic [5:0] bit_cnt_ff;
  logic [31:0] shift_ff;
  logic [7:0] opcode_ff;
  wire op_done = cs_act & sclk_rise & (bit_cnt_ff == 6'h07);
  wire addr_done = cs_act & sclk_rise & (bit_cnt_ff == 6'h1F);
  wire [7:0] op_now = {shift_ff[6:0], mosi_s_ff[1]};
  // count saturates so an over-long frame cannot wrap into a new opcode
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_ff <= 6'h00;
      shift_ff <= 32'h0;
      opcode_ff <= 8'h00;
    end else if (clk_en) begin
      if (!cs_act) begin
        bit_cnt_ff <= 6'h00;
      end else if (sclk_rise) begin
        shift_ff <= {shift_ff[30:0], mosi_s_ff[1]};
        if (bit_cnt_ff != 6'h3F) bit_cnt_ff <= bit_cnt_ff + 6'h01;
        if (op_done) opcode_ff <= op_now;
      end
    end
  end
  wire [FSRC_ADDR_W-1:0] addr_now = {shift_ff[22:0], mosi_s_ff[1]};

  // ----------------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------------
  // one opcode match, shared by every single-byte instruction
  function automatic logic op_hit(input logic done, input logic [7:0] seen, input logic [7:0] code);
    op_hit = done & (seen == code);
  endfunction : op_hit
  // 03h is not decoded: this model keeps no array to read
  wire cmd_suspend = op_hit(op_done, op_now, FSRC_OP_SUSPEND);
  wire cmd_resume = op_hit(op_done, op_now, FSRC_OP_RESUME);
  wire cmd_rdsr = op_hit(op_done, op_now, FSRC_OP_RDSR);

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  fsrc_dstate_t state_ff;
  logic is_erase_ff;
  logic [FSRC_CNT_W-1:0] work_ff, lat_ff;
  wire start_prog = addr_done & (opcode_ff == FSRC_OP_PROGRAM);
  wire start_erase = addr_done & (opcode_ff == FSRC_OP_ERASE);
  // nested operations refused while suspended; the host still sends a program outside a suspended erase's sector, or an erase outside a suspended program's sector
  wire start_ok = (state_ff == FSRC_D_IDLE);
  // state decodes read by status, flags and counters alike
  wire in_susp = (state_ff == FSRC_D_SUSP);
  wire run_end = (work_ff == '0);
  wire lat_end = (lat_ff == '0);
  wire start_any = (start_prog | start_erase) & start_ok;
  // work count is kept across a suspend so a resume continues, not restarts
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= FSRC_D_IDLE;
      is_erase_ff <= 1'b0;
      work_ff <= '0;
      lat_ff <= '0;
      op_addr <= '0;
    end else if (clk_en) begin
      case (state_ff)
        FSRC_D_IDLE: begin
          if (start_any) begin
            state_ff <= FSRC_D_RUN;
            is_erase_ff <= start_erase;
            op_addr <= addr_now;
            work_ff <= FSRC_CNT_W'(FSRC_OP_TIME_CYC);
          end
        end
        FSRC_D_RUN: begin
          if (cmd_suspend) begin
            state_ff <= FSRC_D_SUSPENDING;
            lat_ff <= FSRC_CNT_W'(FSRC_SUSPEND_WORK_CYC);
          end else if (run_end) begin
            state_ff <= FSRC_D_IDLE;
          end else begin
            work_ff <= work_ff - 1'b1;
          end
        end
        // wind-down is well under the 20 us ceiling
        FSRC_D_SUSPENDING: begin
          if (lat_end) state_ff <= FSRC_D_SUSP;
          else lat_ff <= lat_ff - 1'b1;
        end
        FSRC_D_SUSP: begin
          if (cmd_resume) state_ff <= FSRC_D_RUN;
        end
        default: state_ff <= FSRC_D_IDLE;
      endcase
      // suspend in idle or resume when not suspended falls through
    end
  end

  // ----------------------------------------------------------------------
  // status readback: bit 0 busy, bit 7 suspended
  // ----------------------------------------------------------------------
  logic rdsr_ff;
  logic [7:0] sr_shift_ff;
  logic miso_ff, miso_oe_ff;
  wire busy_now = (state_ff == FSRC_D_RUN) | (state_ff == FSRC_D_SUSPENDING);
  wire [7:0] status_now = {in_susp, 6'h00, busy_now};
  // bit 0 leaves on the last fall of a byte; a fresh status is loaded then and when the RDSR opcode is decoded
  wire byte_end = (bit_cnt_ff[2:0] == 3'h7);
  wire [7:0] nxt_sr_shift = byte_end ? status_now : {sr_shift_ff[6:0], 1'b0};
  // miso moves on falls so it is settled long before the host samples it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdsr_ff <= 1'b0;
      sr_shift_ff <= 8'h00;
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else if (clk_en) begin
      if (!cs_act) begin
        rdsr_ff <= 1'b0;
        miso_oe_ff <= 1'b0;
      end else if (cmd_rdsr) begin
        rdsr_ff <= 1'b1;
        sr_shift_ff <= status_now;
      end else if (rdsr_ff & sclk_fall) begin
        // msb first; status repeats every byte while selected
        miso_ff <= sr_shift_ff[7];
        miso_oe_ff <= 1'b1;
        sr_shift_ff <= nxt_sr_shift;
      end
    end
  end
  assign link.miso = miso_ff;
  assign link.miso_oe = miso_oe_ff;

  // ----------------------------------------------------------------------
  // user-side flags
  // ----------------------------------------------------------------------
  // registered so every output of this end comes from a flip-flop
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      suspended <= 1'b0;
      suspend_supported <= 1'b1;
    end else if (clk_en) begin
      busy <= busy_now;
      suspended <= in_susp;
      suspend_supported <= FSRC_SUSPEND_SUPPORTED;
    end
  end
endmodule : fsrc_device

// *** fsrc_pkg.sv ***
/*
  fsrc_pkg: shared constants for the flash suspend/resume control link.
  Assumes: both ends run on mclk at 25 MHz; link is a plain SPI-style
  serial link (sclk, chip select, one data line each way).
*/
package fsrc_pkg;
  // ----------------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] FSRC_OP_SUSPEND = 8'h75;
  localparam logic [7:0] FSRC_OP_RESUME = 8'h7A;
  localparam logic [7:0] FSRC_OP_RDSR = 8'h05;
  localparam logic [7:0] FSRC_OP_PROGRAM = 8'h02;
  localparam logic [7:0] FSRC_OP_ERASE = 8'h20;
  localparam logic [7:0] FSRC_OP_READ = 8'h03;
  // ----------------------------------------------------------------------
  // status and capability fields
  // ----------------------------------------------------------------------
  localparam int FSRC_WIP_BIT = 0;
  localparam int FSRC_SUS_BIT = 7;
  localparam logic FSRC_SUSPEND_SUPPORTED = 1'b0;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int FSRC_CLK_MHZ = 25;
  localparam int FSRC_SUSPEND_LAT_US = 20;
  localparam int FSRC_RESUME_GAP_US = 128;
  // longest time rounds down
  localparam int FSRC_SUSPEND_LAT_CYC = FSRC_SUSPEND_LAT_US * FSRC_CLK_MHZ;
  // least time rounds up (exact here)
  localparam int FSRC_RESUME_GAP_CYC = FSRC_RESUME_GAP_US * FSRC_CLK_MHZ;
  localparam int FSRC_SUSPEND_WORK_CYC = 200;
  localparam int FSRC_OP_TIME_CYC = 4000;
  localparam int FSRC_SCLK_HALF = 4;
  localparam int FSRC_CNT_W = 16;
  localparam int FSRC_ADDR_W = 24;
  localparam int FSRC_SECTOR_LSB = 12;
  localparam int FSRC_PAGE_LSB = 8;
endpackage : fsrc_pkg

// *** fsrc_link_if.sv ***
/*
  fsrc_link_if: serial link between host controller and flash device.
  Assumes: testbench instantiates it and ties both modports to the ends.
*/
`timescale 1ns/1ns
interface fsrc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport host (output sclk, output cs_n, output mosi, input miso);
  modport device (input sclk, input cs_n, input mosi, output miso, output miso_oe);
endinterface : fsrc_link_if

// *** fsrc_host.sv ***
/*
  fsrc_host: host controller end; sends one instruction per request and
  enforces the resume-to-suspend gap and suspended-region restrictions.
  Assumes: user holds req until ack; miso arrives from another domain.
*/
`timescale 1ns/1ns
module fsrc_host
  import fsrc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  fsrc_link_if.host link,
  input wire logic req,
  input wire logic [7:0] req_op,
  input wire logic [FSRC_ADDR_W-1:0] req_addr,
  output logic ack,
  output logic refused,
  output logic [7:0] status
);
  typedef enum logic [1:0] {FSRC_H_IDLE, FSRC_H_SHIFT, FSRC_H_DONE} fsrc_hstate_t;

  // ----------------------------------------------------------------------
  // restriction decode
  // ----------------------------------------------------------------------
  fsrc_hstate_t state_ff;
  logic susp_ff, susp_erase_ff, pend_erase_ff, gap_ok_ff;
  logic [FSRC_ADDR_W-1:0] susp_addr_ff, pend_addr_ff;
  logic [FSRC_CNT_W-1:0] gap_ff;
  function automatic logic same_region(input logic [FSRC_ADDR_W-1:0] a,
                                       input logic [FSRC_ADDR_W-1:0] b, input logic sector);
    same_region = sector ? (a[FSRC_ADDR_W-1:FSRC_SECTOR_LSB] == b[FSRC_ADDR_W-1:FSRC_SECTOR_LSB])
                         : (a[FSRC_ADDR_W-1:FSRC_PAGE_LSB] == b[FSRC_ADDR_W-1:FSRC_PAGE_LSB]);
  endfunction : same_region
  wire hit_sector = same_region(req_addr, susp_addr_ff, 1'b1);
  wire hit_page = same_region(req_addr, susp_addr_ff, 1'b0);
  wire is_er = req_op == FSRC_OP_ERASE;
  wire is_pp = req_op == FSRC_OP_PROGRAM;
  wire is_rd = req_op == FSRC_OP_READ;
  wire bad_erase_susp = susp_ff & susp_erase_ff & (is_er | (is_pp & hit_sector)
                        | (is_rd & hit_sector));
  // an erase clears a whole sector, so it covers the suspended page whenever the sectors match
  wire bad_prog_susp = susp_ff & ~susp_erase_ff & ((is_er & hit_sector) | is_pp
                       | (is_rd & hit_page));
  wire bad_gap = (req_op == FSRC_OP_SUSPEND) & ~gap_ok_ff;
  wire has_addr = is_er | is_pp | is_rd;
  wire take = req & (state_ff == FSRC_H_IDLE) & ~ack & ~refused;
  wire bad = bad_erase_susp | bad_prog_susp | bad_gap;

  // ----------------------------------------------------------------------
  // suspend bookkeeping and resume gap timer
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      susp_ff <= 1'b0;
      susp_erase_ff <= 1'b0;
      pend_erase_ff <= 1'b0;
      susp_addr_ff <= '0;
      pend_addr_ff <= '0;
      gap_ff <= '0;
      gap_ok_ff <= 1'b1;
    end else if (clk_en) begin
      gap_ok_ff <= (gap_ff == '0);
      if (gap_ff != '0) gap_ff <= gap_ff - 1'b1;
      if (take & ~bad) begin
        if (is_er | is_pp) begin
          pend_erase_ff <= is_er;
          pend_addr_ff <= req_addr;
        end
        if (req_op == FSRC_OP_SUSPEND) begin
          susp_ff <= 1'b1;
          susp_erase_ff <= pend_erase_ff;
          susp_addr_ff <= pend_addr_ff;
        end
        if (req_op == FSRC_OP_RESUME) begin
          susp_ff <= 1'b0;
          gap_ff <= FSRC_CNT_W'(FSRC_RESUME_GAP_CYC);
          gap_ok_ff <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // serial engine: sclk divided from mclk, mode 0
  // ----------------------------------------------------------------------
  logic [1:0] miso_s_ff;
  logic [5:0] nbits_ff, bit_ff;
  logic [2:0] div_ff;
  logic [31:0] tx_ff;
  logic [7:0] rx_ff;
  logic sclk_ff, cs_n_ff;
  wire tick = div_ff == 3'(FSRC_SCLK_HALF - 1);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      miso_s_ff <= 2'h0;
      state_ff <= FSRC_H_IDLE;
      nbits_ff <= 6'h00;
      bit_ff <= 6'h00;
      div_ff <= 3'h0;
      tx_ff <= 32'h0;
      rx_ff <= 8'h00;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      ack <= 1'b0;
      refused <= 1'b0;
      status <= 8'h00;
    end else if (clk_en) begin
      miso_s_ff <= {miso_s_ff[0], link.miso};
      ack <= 1'b0;
      refused <= take & bad;
      div_ff <= tick ? 3'h0 : div_ff + 3'h1;
      case (state_ff)
        FSRC_H_IDLE: begin
          if (take & ~bad) begin
            state_ff <= FSRC_H_SHIFT;
            cs_n_ff <= 1'b0;
            sclk_ff <= 1'b0;
            div_ff <= 3'h0;
            bit_ff <= 6'h00;
            tx_ff <= {req_op, req_addr};
            // status read: opcode plus one byte in
            nbits_ff <= has_addr ? 6'h20 : ((req_op == FSRC_OP_RDSR) ? 6'h10 : 6'h08);
          end
        end
        FSRC_H_SHIFT: begin
          if (tick) begin
            sclk_ff <= ~sclk_ff;
            if (sclk_ff) begin
              // sampled late, at the fall: the device answers a fall only after its
              // synchroniser and ours adds two cycles more, so a rise is too early
              rx_ff <= {rx_ff[6:0], miso_s_ff[1]};
              tx_ff <= {tx_ff[30:0], 1'b0};
              bit_ff <= bit_ff + 6'h01;
              if (bit_ff + 6'h01 == nbits_ff) state_ff <= FSRC_H_DONE;
            end
          end
        end
        FSRC_H_DONE: begin
          if (tick) begin
            cs_n_ff <= 1'b1;
            status <= rx_ff;
            ack <= 1'b1;
            state_ff <= FSRC_H_IDLE;
          end
        end
        default: state_ff <= FSRC_H_IDLE;
      endcase
    end
  end
  assign link.sclk = sclk_ff;
  assign link.cs_n = cs_n_ff;
  assign link.mosi = tx_ff[31];
endmodule : fsrc_host

// *** fsrc_asserts.sv ***
/*
  fsrc_asserts: wire-level checks on the serial link between the two ends.
  Assumes: instantiated beside the link interface, all signals seen on mclk.
*/
`timescale 1ns/1ns
module fsrc_asserts (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // ----------------------------------------------------------------------
  // helper: count serial clock rises inside a frame
  // ----------------------------------------------------------------------
  logic sclk_q_ff;
  logic [5:0] bit_cnt_ff;
  wire logic sclk_rise = sclk & ~sclk_q_ff;
  wire logic [5:0] nxt_bit_cnt = cs_n ? 6'h00 : bit_cnt_ff + {5'h00, sclk_rise};
  // cleared between frames so a short frame never hides in the next one
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q_ff <= 1'b0;
      bit_cnt_ff <= 6'h00;
    end else begin
      sclk_q_ff <= sclk;
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end
  // ----------------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_sclk_idle; cs_n |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk not low outside a frame");
  property p_cs_start; $fell(cs_n) |-> !sclk ##1 !sclk; endproperty
  a_cs_start: assert property (p_cs_start) else $error("frame opened with sclk high");
  property p_mosi_rise; $rose(sclk) |-> $stable(mosi); endproperty
  a_mosi_rise: assert property (p_mosi_rise) else $error("mosi moved at sclk rise");
  property p_mosi_high; sclk && $past(sclk) |-> $stable(mosi); endproperty
  a_mosi_high: assert property (p_mosi_high) else $error("mosi moved while sclk high");
  property p_sclk_high; $rose(sclk) |=> sclk[*3] ##1 !sclk; endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("sclk high phase not 4 cycles");
  property p_sclk_low; $fell(sclk) && !cs_n |=> !sclk[*3]; endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("sclk low phase too short");
  property p_oe_idle; cs_n && $past(cs_n, 8) |-> !miso_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");
  property p_frame_bytes; $rose(cs_n) |-> bit_cnt_ff[2:0] == 3'h0 && bit_cnt_ff != 6'h00;
  endproperty
  a_frame_bytes: assert property (p_frame_bytes) else $error("frame not whole bytes");
  c_frame: cover property ($rose(cs_n) && bit_cnt_ff == 6'h20);
endmodule : fsrc_asserts

// *** flash_suspend_resume_control_tb.sv ***
/*
  flash_suspend_resume_control_tb: host end and device end joined by one link.
  Assumes: both ends on mclk at 25 MHz; host makes sclk itself by division.
*/
`timescale 1ns/1ns
module flash_suspend_resume_control_tb;
  import fsrc_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic req = 1'b0;
  logic [7:0] req_op = 8'h00;
  logic [FSRC_ADDR_W-1:0] req_addr = 24'h000000;
  logic ack, refused, busy, suspended, suspend_supported;
  logic [7:0] status;
  logic [FSRC_ADDR_W-1:0] op_addr;
  int err_count = 0;
  int n_checks = 0;
  fsrc_link_if link ();
  fsrc_host u_fsrc_host (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .link(link),
    .req(req), .req_op(req_op), .req_addr(req_addr), .ack(ack), .refused(refused),
    .status(status));
  fsrc_device u_fsrc_device (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .link(link),
    .busy(busy), .suspended(suspended), .suspend_supported(suspend_supported),
    .op_addr(op_addr));
  fsrc_asserts u_fsrc_asserts (.mclk(mclk), .reset_n(reset_n), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
  // 40 ns period
  always #20 mclk = ~mclk;
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one instruction, held until answered; compares the refusal bit
  task automatic send(input logic [7:0] op, input logic [23:0] addr, input logic exp_ref);
    int n;
    n = 0;
    req = 1'b1;
    req_op = op;
    req_addr = addr;
    @(negedge mclk);
    while (ack !== 1'b1 && refused !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 2000) begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
    chk({31'h0, refused}, {31'h0, exp_ref});
    req = 1'b0;
    @(negedge mclk);
  endtask : send
  // bounded wait on busy (sel 0) or suspended (sel 1); gives cycles taken
  task automatic wait_lvl(input logic sel, input logic val, input int bound, output int cyc);
    cyc = 0;
    while (((sel ? suspended : busy) !== val) && cyc < bound) begin
      @(negedge mclk);
      cyc++;
    end
    if (cyc >= bound) begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
  endtask : wait_lvl
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_idle();
    int c;
    chk({31'h0, suspend_supported}, {31'h0, FSRC_SUSPEND_SUPPORTED});
    send(FSRC_OP_SUSPEND, 24'h000000, 1'b0);
    wait_lvl(1'b0, 1'b0, 8, c);
    chk({31'h0, suspended}, 32'h0);
    send(FSRC_OP_RESUME, 24'h000000, 1'b0);
    chk({31'h0, suspended}, 32'h0);
    // even an ignored resume opens the host's resume-to-suspend gap
    repeat (FSRC_RESUME_GAP_CYC) @(negedge mclk);
    $display("test idle done");
  endtask : t_idle
  // suspend the running op, prove the latency bound, then the forbidden set
  task automatic t_erase();
    int c;
    send(FSRC_OP_ERASE, 24'h001000, 1'b0);
    send(FSRC_OP_RDSR, 24'h000000, 1'b0);
    chk({31'h0, status[FSRC_WIP_BIT]}, 32'h1);
    send(FSRC_OP_SUSPEND, 24'h000000, 1'b0);
    wait_lvl(1'b1, 1'b1, FSRC_SUSPEND_LAT_CYC, c);
    chk({8'h00, op_addr}, 32'h00001000);
    send(FSRC_OP_RDSR, 24'h000000, 1'b0);
    chk({31'h0, status[FSRC_SUS_BIT]}, 32'h1);
    send(FSRC_OP_ERASE, 24'h005000, 1'b1);
    send(FSRC_OP_PROGRAM, 24'h001234, 1'b1);
    send(FSRC_OP_READ, 24'h001FFF, 1'b1);
    send(FSRC_OP_READ, 24'h002000, 1'b0);
    send(FSRC_OP_RESUME, 24'h000000, 1'b0);
    wait_lvl(1'b1, 1'b0, 16, c);
    send(FSRC_OP_SUSPEND, 24'h000000, 1'b1);
    repeat (FSRC_RESUME_GAP_CYC) @(negedge mclk);
    send(FSRC_OP_SUSPEND, 24'h000000, 1'b0);
    wait_lvl(1'b1, 1'b1, FSRC_SUSPEND_LAT_CYC, c);
    send(FSRC_OP_RESUME, 24'h000000, 1'b0);
    wait_lvl(1'b0, 1'b0, 3 * FSRC_OP_TIME_CYC, c);
    send(FSRC_OP_RDSR, 24'h000000, 1'b0);
    chk({24'h0, status}, 32'h0);
    $display("test erase done");
  endtask : t_erase
  task automatic t_program();
    int c;
    // the last resume of the erase test still holds the suspend gap open
    repeat (FSRC_RESUME_GAP_CYC) @(negedge mclk);
    send(FSRC_OP_PROGRAM, 24'h003100, 1'b0);
    send(FSRC_OP_SUSPEND, 24'h000000, 1'b0);
    wait_lvl(1'b1, 1'b1, FSRC_SUSPEND_LAT_CYC, c);
    send(FSRC_OP_ERASE, 24'h003000, 1'b1);
    send(FSRC_OP_PROGRAM, 24'h007000, 1'b1);
    send(FSRC_OP_READ, 24'h0031FF, 1'b1);
    send(FSRC_OP_READ, 24'h003200, 1'b0);
    send(FSRC_OP_RESUME, 24'h000000, 1'b0);
    wait_lvl(1'b1, 1'b0, 16, c);
    send(FSRC_OP_SUSPEND, 24'h000000, 1'b1);
    wait_lvl(1'b0, 1'b0, 3 * FSRC_OP_TIME_CYC, c);
    chk({31'h0, suspended}, 32'h0);
    $display("test program done");
  endtask : t_program
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_idle();
    t_erase();
    t_program();
    wrap_up();
  end
endmodule : flash_suspend_resume_control_tb
